// >>> design/acri_top.v
`timescale 1ns/1ps
`include "acri_map.vh"
// Behaviour
// - Falling convert strobe starts a conversion unless a serial transfer is running; it always completes, strobe or power-down ignored.
// - Convert strobe acts independently of chip-select and read-enable.
// - Low-power auto mode: strobe held low repeats conversions after a timed acquisition.
// - Self-repeat only in low-power auto mode, never in fast or normal modes.
// - Low-power auto mode lowers current after conversion; interface stays active.
// - Outputs released unless chip-select and read-enable are both low.
// - Format select picks straight binary or twos complement.
// - Overrange gives FFFF binary, 7FFF twos complement; MSB inversion.
// - Underrange gives 0000 binary, 8000 twos complement; midscale maps likewise.
// - Serial select low presents result on parallel bus.
// - Byte order low: low byte on D[7:0]; high: bytes swapped.
// - Serial select high shifts 16 bits MSB first, one per clock pulse.
// - Each serial bit stays valid across the rising shift clock edge.
// - Serial data and master shift clock share pins with the parallel data bus; external shift clock has its own input.
// - Clock source low: device generates shift clock and frame signal.
// - Master shift clock and frame polarity each invertible.
// - Read mode selects read after conversion or previous result during conversion.
// - Read-during transfers start only on the first cycle of a conversion.
// - Master read-after mode: busy stays high until 16 bits shifted.
// - External shift clock gated by chip-select; data only with both selects low.
module acri_top #(
  parameter RD_AFTER_LEVEL = 1'b1
) (
  // Clock, reset, enable
  input  wire        clk,
  input  wire        resetn,
  input  wire        clk_en,
  // Conversion control
  input  wire        convert_strobe_n,
  input  wire        power_down_in,
  input  wire [1:0]  speed_mode,
  input  wire [15:0] sample_code,
  output reg         busy,
  output wire        low_power_active,
  // Readout configuration
  input  wire        cs_n,
  input  wire        rd_n,
  input  wire        code_format_select,
  input  wire        serial_parallel_select,
  input  wire        byte_order_select,
  input  wire        clock_source_select,
  input  wire        read_mode_chain_in,
  input  wire        sclk_invert,
  input  wire        frame_invert,
  input  wire        ext_sclk,
  // Shared data bus
  output reg  [15:0] data_out,
  output wire [15:0] data_oe_n,
  output wire        serial_data_out,
  output wire        sclk_out,
  output wire        frame_out
);

  localparam ST_IDLE = 3'b001;
  localparam ST_CONV = 3'b010;
  localparam ST_ACQ  = 3'b100;

  // Input synchronisers
  reg [1:0] cnv_s_reg;
  reg [1:0] pd_s_reg;
  reg [1:0] cs_s_reg;
  reg [1:0] rd_s_reg;
  reg [1:0] ext_s_reg;
  reg [1:0] rdm_s_reg;
  reg       cnv_d_reg;
  reg       ext_d_reg;
  always @(posedge clk) begin
    if (!resetn) begin
      cnv_s_reg <= 2'h3;
      pd_s_reg  <= 2'h0;
      cs_s_reg  <= 2'h3;
      rd_s_reg  <= 2'h3;
      ext_s_reg <= 2'h0;
      rdm_s_reg <= 2'h0;
    end else if (clk_en) begin
      cnv_s_reg <= {cnv_s_reg[0], convert_strobe_n};
      pd_s_reg  <= {pd_s_reg[0], power_down_in};
      cs_s_reg  <= {cs_s_reg[0], cs_n};
      rd_s_reg  <= {rd_s_reg[0], rd_n};
      ext_s_reg <= {ext_s_reg[0], ext_sclk};
      rdm_s_reg <= {rdm_s_reg[0], read_mode_chain_in};
    end
  end

  // Edge detect on synchronised strobe and link clock
  always @(posedge clk) begin
    if (!resetn) begin
      cnv_d_reg <= 1'b1;
      ext_d_reg <= 1'b0;
    end else if (clk_en) begin
      cnv_d_reg <= cnv_s_reg[1];
      ext_d_reg <= ext_s_reg[1];
    end
  end

  wire cnv_n    = cnv_s_reg[1];
  wire cnv_fall = cnv_d_reg & ~cnv_n;
  wire pd       = pd_s_reg[1];
  wire sel_n    = cs_s_reg[1] | rd_s_reg[1];
  wire ext_rise = ext_s_reg[1] & ~ext_d_reg;
  wire impulse  = speed_mode[1];
  wire master   = serial_parallel_select & ~clock_source_select;
  wire rd_after = (rdm_s_reg[1] == RD_AFTER_LEVEL);

  reg [9:0] conv_len;
  always @* begin
    case (speed_mode)
      `ACRI_MODE_FAST: conv_len = `ACRI_CONV_CYC_FAST;
      `ACRI_MODE_NORM: conv_len = `ACRI_CONV_CYC_NORM;
      default:         conv_len = `ACRI_CONV_CYC_IMPULSE;
    endcase
  end

  // Conversion sequencer
  reg [2:0]  state_reg;
  reg [9:0]  cnt_reg;
  reg [15:0] result_reg;
  reg [15:0] prev_reg;
  reg        done_reg;
  reg        xfer_reg;
  reg [4:0]  bit_reg;
  reg [3:0]  div_reg;
  reg        sclk_reg;
  reg        xfer_after_reg;

  wire conv_first_half = (state_reg == ST_CONV) && (cnt_reg < {1'b0, conv_len[9:1]});
  wire conv_end        = (state_reg == ST_CONV) && (cnt_reg == conv_len - 10'd1);

  always @(posedge clk) begin
    if (!resetn) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 10'd0;
      result_reg <= 16'h0000;
      done_reg   <= 1'b0;
    end else if (clk_en) begin
      done_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 10'd0;
          if (cnv_fall && !xfer_reg) begin
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          cnt_reg <= cnt_reg + 10'd1;
          if (conv_end) begin
            result_reg <= sample_code;
            done_reg   <= 1'b1;
            cnt_reg    <= 10'd0;
            state_reg  <= (impulse && !cnv_n && !pd) ? ST_ACQ : ST_IDLE;
          end
        end
        ST_ACQ: begin
          cnt_reg <= cnt_reg + 10'd1;
          if (cnv_n || pd) begin
            state_reg <= ST_IDLE;
          end else if (cnt_reg == `ACRI_ACQ_CYC - 10'd1 && !xfer_reg) begin
            cnt_reg   <= 10'd0;
            state_reg <= ST_CONV;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Low current between conversions in auto mode
  assign low_power_active = impulse && (state_reg != ST_CONV);

  // Result coding
  wire [15:0] coded = {result_reg[15] ^ code_format_select, result_reg[14:0]};

  // Serial transfer engine
  wire start_after  = done_reg && master && rd_after;
  wire start_during = master && !rd_after && conv_first_half
                      && (cnt_reg == 10'd0);
  wire ext_mode     = serial_parallel_select & clock_source_select;
  wire [15:0] shift_word = (xfer_after_reg || ext_mode) ? coded
                           : {prev_reg[15] ^ code_format_select, prev_reg[14:0]};
  wire sclk_tick    = master ? (div_reg == `ACRI_SCLK_HALF) : ext_rise;
  wire ext_start    = ext_mode && !sel_n && !xfer_reg && ext_rise;

  always @(posedge clk) begin
    if (!resetn) begin
      xfer_reg       <= 1'b0;
      xfer_after_reg <= 1'b0;
      bit_reg        <= 5'd0;
      div_reg        <= 4'h0;
      sclk_reg       <= 1'b0;
      prev_reg       <= 16'h0000;
    end else if (clk_en) begin
      if (start_during && !xfer_reg) begin
        prev_reg <= result_reg;
      end
      if (!xfer_reg) begin
        div_reg  <= 4'h0;
        sclk_reg <= 1'b0;
        bit_reg  <= 5'd0;
        if (start_after || start_during) begin
          xfer_reg       <= 1'b1;
          xfer_after_reg <= start_after;
        end else if (ext_start) begin
          xfer_reg       <= 1'b1;
          xfer_after_reg <= 1'b1;
          bit_reg        <= 5'd1;
        end
      end else if (ext_mode) begin
        if (sel_n) begin
          xfer_reg <= 1'b0;
        end else if (ext_rise) begin
          bit_reg <= bit_reg + 5'd1;
          if (bit_reg == `ACRI_BITS - 5'd1) begin
            xfer_reg <= 1'b0;
          end
        end
      end else begin
        div_reg <= (div_reg == `ACRI_SCLK_HALF) ? 4'h0 : div_reg + 4'h1;
        if (sclk_tick) begin
          sclk_reg <= ~sclk_reg;
          if (sclk_reg) begin
            bit_reg <= bit_reg + 5'd1;
            if (bit_reg == `ACRI_BITS - 5'd1) begin
              xfer_reg <= 1'b0;
            end
          end
        end
      end
    end
  end

  // Busy flag
  reg busy_next;
  always @* begin
    busy_next = 1'b0;
    if (state_reg == ST_CONV) begin
      if (!conv_end) begin
        busy_next = 1'b1;
      end else if (master && rd_after) begin
        busy_next = 1'b1;
      end
    end
    if (start_after) begin
      busy_next = 1'b1;
    end
    if (xfer_reg && xfer_after_reg && master) begin
      busy_next = 1'b1;
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      busy <= 1'b0;
    end else if (clk_en) begin
      busy <= busy_next;
    end
  end

  // Shared bus drive
  wire [3:0]  bit_idx  = 4'hF - bit_reg[3:0];
  wire        ser_live = xfer_reg || (ext_mode && !sel_n);
  reg  [15:0] data_next;
  always @* begin
    data_next = 16'h0000;
    if (!serial_parallel_select) begin
      if (byte_order_select) begin
        data_next = {coded[7:0], coded[15:8]};
      end else begin
        data_next = coded;
      end
    end else begin
      data_next[0] = ser_live ? shift_word[bit_idx] : 1'b0;
      if (master) begin
        data_next[1] = sclk_reg ^ sclk_invert;
      end
    end
  end

  always @(posedge clk) begin
    if (!resetn) begin
      data_out <= 16'h0000;
    end else if (clk_en) begin
      data_out <= data_next;
    end
  end

  assign serial_data_out = data_out[0];
  assign sclk_out        = data_out[1];
  assign frame_out       = (xfer_reg & master) ^ frame_invert;
  assign data_oe_n       = {16{sel_n}};

endmodule // acri_top

// >>> design/acri_map.vh
`ifndef ACRI_MAP_VH
`define ACRI_MAP_VH
// Conversion phase length in clk cycles, per speed mode
`define ACRI_CONV_CYC_FAST    10'd28
`define ACRI_CONV_CYC_NORM    10'd34
`define ACRI_CONV_CYC_IMPULSE 10'd40
// Self-timed acquisition in low-power auto mode
`define ACRI_ACQ_CYC          10'd20
// Speed mode encodings
`define ACRI_MODE_FAST        2'h0
`define ACRI_MODE_NORM        2'h1
`define ACRI_MODE_IMPULSE     2'h2
// Master shift clock half period in clk cycles, minus one
`define ACRI_SCLK_HALF        4'h1
`define ACRI_BITS             5'd16
// Result codes at range limits
`define ACRI_CODE_OVER        16'hFFFF
`define ACRI_CODE_UNDER       16'h0000
`endif

// >>> dv/acri_top_properties.sv
`timescale 1ns/1ps
module acri_chk #(parameter RD_AFTER_LEVEL = 1'b1) (
  // Inputs
  input wire logic        clk, resetn, convert_strobe_n, power_down_in,
  input wire logic [1:0]  speed_mode,
  input wire logic        cs_n, rd_n, serial_parallel_select, clock_source_select,
  input wire logic        read_mode_chain_in, sclk_invert, frame_invert,
  // Outputs
  input wire logic        busy, low_power_active, serial_data_out, sclk_out, frame_out,
  input wire logic [15:0] data_oe_n
);
  wire       xfer = frame_out ^ frame_invert;
  wire       mser = serial_parallel_select && !clock_source_select;
  wire       sck  = sclk_out ^ sclk_invert;
  reg        sck_reg;
  reg  [4:0] nbits_reg;
  // Shift clock rises per frame
  always @(posedge clk) begin
    sck_reg <= sck;
    if (!resetn || !xfer) nbits_reg <= 5'h00;
    else if (sck && !sck_reg) nbits_reg <= nbits_reg + 5'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_conv_min; busy[*8] ##1 busy[*8] ##1 busy[*8]; endsequence
  sequence s_held_low;
    ($fell(busy) && !speed_mode[1] && !convert_strobe_n) ##1 (!convert_strobe_n)[*8];
  endsequence
  a_conv_runs: assert property ($rose(busy) |-> s_conv_min)
    else $error("busy fell too soon");
  a_no_repeat: assert property (s_held_low |-> !busy)
    else $error("self repeat outside auto mode");
  a_auto_repeat: assert property ($fell(busy) && speed_mode[1] && !convert_strobe_n
    && !power_down_in |-> ##[1:40] (busy || convert_strobe_n || power_down_in))
    else $error("auto conversion did not restart");
  a_oe_off: assert property ((cs_n || rd_n)[*3] |-> data_oe_n == 16'hFFFF)
    else $error("bus driven while deselected");
  a_lowpower_mode: assert property (!speed_mode[1] |-> !low_power_active)
    else $error("low power outside auto mode");
  a_bit_stable: assert property (mser && xfer && $past(xfer) && sck
    |-> $stable(serial_data_out)) else $error("serial bit moved on clock high");
  a_frame_bits: assert property ($fell(xfer) && mser |-> nbits_reg == 5'h10)
    else $error("frame bit count wrong");
  a_busy_spans: assert property ($rose(xfer) && mser
    && read_mode_chain_in == RD_AFTER_LEVEL |-> busy) else $error("busy low in frame");
endmodule // acri_chk
bind acri_top acri_chk #(.RD_AFTER_LEVEL(RD_AFTER_LEVEL)) u_chk (.clk, .resetn,
  .convert_strobe_n, .power_down_in, .speed_mode, .cs_n, .rd_n, .serial_parallel_select,
  .clock_source_select, .read_mode_chain_in, .sclk_invert, .frame_invert, .busy,
  .low_power_active, .serial_data_out, .sclk_out, .frame_out, .data_oe_n);

// >>> dv/acri_host.sv
`timescale 1ns/1ps
module acri_host (
  // Control
  input  wire logic        go,
  input  wire logic        sdo,
  // Clock and result
  output logic             sck,
  output logic [15:0]      word,
  output logic             done
);
  initial begin
    sck = 1'b0;
    word = 16'h0000;
    done = 1'b0;
  end
  // Sixteen pulses, idle low between frames
  always @(posedge go) begin
    done = 1'b0;
    repeat (16) begin
      #100 sck = 1'b1;
      word = {word[14:0], sdo};
      #100 sck = 1'b0;
    end
    done = 1'b1;
  end
endmodule // acri_host

// >>> dv/acri_top_tb.sv
`timescale 1ns/1ps
`include "acri_map.vh"
module acri_top_tb;
  logic clk = 1'b0, resetn = 1'b0, convert_strobe_n = 1'b1, power_down_in = 1'b0;
  logic [1:0] speed_mode = 2'h0;
  logic [15:0] sample_code = 16'h0000;
  logic cs_n = 1'b1, rd_n = 1'b1, code_format_select = 1'b0, serial_parallel_select = 1'b0;
  logic byte_order_select = 1'b0, clock_source_select = 1'b0, read_mode_chain_in = 1'b1;
  logic sclk_invert = 1'b0, frame_invert = 1'b0, go = 1'b0;
  wire busy, low_power_active, serial_data_out, sclk_out, frame_out, ext_sclk, hdone;
  wire [15:0] data_out, data_oe_n, hword;
  int miscompares = 0, n_checks = 0;
  always #12.5 clk = ~clk;
  acri_top dut (.clk, .resetn, .clk_en(1'b1), .convert_strobe_n, .power_down_in,
    .speed_mode, .sample_code, .busy, .low_power_active, .cs_n, .rd_n, .code_format_select,
    .serial_parallel_select, .byte_order_select, .clock_source_select, .read_mode_chain_in,
    .sclk_invert, .frame_invert, .ext_sclk, .data_out, .data_oe_n, .serial_data_out,
    .sclk_out, .frame_out);
  acri_host host (.go, .sdo(serial_data_out), .sck(ext_sclk), .word(hword), .done(hdone));
  task tick; @(posedge clk); #2; endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task close_out;
    if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wait_lvl(input logic v);
    for (int i = 0; i < 400 && busy !== v; i++) tick;
    if (busy !== v) begin
      miscompares++;
      close_out;
    end
  endtask
  task convert;
    convert_strobe_n = 1'b0;
    tick;
    convert_strobe_n = 1'b1;
    wait_lvl(1'b1);
  endtask
  // Codes, formats, byte order, restrobe and power-down mid conversion
  task t_parallel;
    logic [15:0] e;
    logic [15:0] codes [3];
    codes = '{16'hFFFF, 16'h0000, 16'h8000};
    for (int k = 0; k < 12; k++) begin
      sample_code = codes[k % 3];
      speed_mode = 2'(k % 3);
      code_format_select = (k / 3) % 2 == 1;
      byte_order_select = k >= 6;
      cs_n = 1'b0;
      convert;
      power_down_in = 1'b1;
      convert_strobe_n = 1'b0;
      tick;
      convert_strobe_n = 1'b1;
      repeat (20) tick;
      check({15'h0000, busy}, 16'h0001);
      wait_lvl(1'b0);
      power_down_in = 1'b0;
      rd_n = 1'b0;
      repeat (4) tick;
      e = sample_code ^ (code_format_select ? 16'h8000 : 16'h0000);
      if (byte_order_select) e = {e[7:0], e[15:8]};
      check(data_out, e);
      check(data_oe_n, 16'h0000);
      rd_n = 1'b1;
      repeat (3) tick;
      check(data_oe_n, 16'hFFFF);
      cs_n = 1'b1;
    end
  endtask
  // Strobe held low in every speed mode
  task t_auto;
    int n;
    logic pb;
    for (int m = 0; m < 4; m++) begin
      speed_mode = 2'(m);
      n = 0;
      pb = busy;
      convert_strobe_n = 1'b0;
      repeat (300) begin
        tick;
        if (busy && !pb) n++;
        pb = busy;
      end
      convert_strobe_n = 1'b1;
      wait_lvl(1'b0);
      repeat (60) tick;
      wait_lvl(1'b0);
      check({15'h0000, n > 1}, {15'h0000, m >= 2});
    end
  endtask
  // Master serial: plain, inverted, read during conversion
  task t_master;
    logic [15:0] w, c, prev;
    logic pk, s, hb;
    int n;
    serial_parallel_select = 1'b1;
    code_format_select = 1'b0;
    speed_mode = `ACRI_MODE_FAST;
    for (int j = 0; j < 3; j++) begin
      sclk_invert = j == 1;
      frame_invert = j == 1;
      read_mode_chain_in = j != 2;
      c = j == 1 ? 16'h3C96 : 16'hA5C3;
      prev = sample_code;
      sample_code = c;
      convert;
      w = 16'h0000;
      n = 0;
      hb = 1'b1;
      pk = sclk_out ^ sclk_invert;
      for (int i = 0; i < 600 && n < 16; i++) begin
        tick;
        s = sclk_out ^ sclk_invert;
        if ((frame_out ^ frame_invert) && s && !pk) begin
          w = {w[14:0], serial_data_out};
          hb = hb & busy;
          n++;
        end
        pk = s;
      end
      if (n < 16) begin
        miscompares++;
        close_out;
      end
      check(w, j == 2 ? prev : c);
      if (j != 2) check({15'h0000, hb}, 16'h0001);
      wait_lvl(1'b0);
      repeat (100) tick;
    end
  endtask
  // Host-clocked serial read after conversion
  task t_ext;
    clock_source_select = 1'b1;
    read_mode_chain_in = 1'b1;
    sample_code = 16'h5A3C;
    convert;
    wait_lvl(1'b0);
    cs_n = 1'b0;
    rd_n = 1'b0;
    repeat (4) tick;
    go = 1'b1;
    for (int i = 0; i < 200 && !hdone; i++) tick;
    go = 1'b0;
    if (hdone !== 1'b1) begin
      miscompares++;
      close_out;
    end
    check(hword, 16'h5A3C);
  endtask
  initial begin
    repeat (8) tick;
    resetn = 1'b1;
    repeat (4) tick;
    t_parallel;
    t_auto;
    t_master;
    t_ext;
    close_out;
  end
endmodule // acri_top_tb
